// [shared/asx_cfg.svh]
// Register map, field positions, flag layout and clock counts of the add/subtract unit.
`ifndef ASX_CFG_SVH
`define ASX_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ASX_A_CMD      8'h00
`define ASX_A_IMM      8'h04
`define ASX_A_MADDR    8'h08
`define ASX_A_FLAGS    8'h0C
`define ASX_A_STATUS   8'h10
`define ASX_A_RF_HI    3'h1

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define ASX_C_OP_LO    0
`define ASX_C_FORM_LO  2
`define ASX_C_WORD     5
`define ASX_C_DST_LO   6
`define ASX_C_SRC_LO   9
`define ASX_C_START    31

// ----------------------------------------------------------------
// Flag bit positions and reset value
// ----------------------------------------------------------------
`define ASX_FL_OVF     5
`define ASX_FL_SIGN    4
`define ASX_FL_ZERO    3
`define ASX_FL_HALF    2
`define ASX_FL_PAR     1
`define ASX_FL_CARRY   0
`define ASX_FL_RST     6'h00

// ----------------------------------------------------------------
// Clock counts per form
// ----------------------------------------------------------------
`define ASX_T_RR       5'h02
`define ASX_T_IMM      5'h04
`define ASX_T_RM_S     5'h0B
`define ASX_T_RM_L     5'h0F
`define ASX_T_MR_S     5'h10
`define ASX_T_MR_L     5'h18
`define ASX_T_MI_S     5'h12
`define ASX_T_MI_L     5'h1A
`define ASX_RD_CAP     5'h06

`endif

// [shared/asx_pkg.sv]
// Types shared by the add/subtract unit.
package asx_pkg;

    // Arithmetic operation of a command.
    typedef enum logic [1:0] {
        ASX_ADD,
        ASX_ADD_PC,
        ASX_SUB,
        ASX_SUB_WB
    } asx_op_t;

    // Operand form of a command.
    typedef enum logic [2:0] {
        ASX_RR,
        ASX_MR,
        ASX_RM,
        ASX_RI,
        ASX_MI,
        ASX_AI
    } asx_form_t;

    // Sequencer states.
    typedef enum logic {
        ASX_IDLE,
        ASX_RUN
    } asx_state_t;

endpackage : asx_pkg

// [logic/asx_core.sv]
// Add/subtract execution unit with a register file, flags and a memory operand port.
`include "asx_cfg.svh"

// What this block does
// RULE_01: Register plus immediate, four clocks, no bus.
// RULE_02: Memory plus immediate written back, 18/26 clocks.
// RULE_03: Accumulator plus immediate, four clocks, no bus.
// RULE_04: Register plus register plus carry, two clocks.
// RULE_05: Memory plus register plus carry, 16/24 clocks.
// RULE_06: Register plus memory plus carry, 11/15 clocks.
// RULE_07: Register plus immediate plus carry, four clocks.
// RULE_08: Memory plus immediate plus carry, 18/26 clocks.
// RULE_09: Accumulator plus immediate plus carry, four clocks.
// RULE_10: Register minus register, two clocks, no bus.
// RULE_11: Memory minus register written back, 16/24 clocks.
// RULE_12: Register minus memory, one read, 11/15 clocks.
// RULE_13: Register minus immediate, four clocks, no bus.
// RULE_14: Memory minus immediate written back, 18/26 clocks.
// RULE_15: Accumulator minus immediate, four clocks, no bus.
// RULE_16: Register minus register minus carry, two clocks.
// RULE_17: Memory minus register minus carry, 16/24 clocks.
// RULE_18: Register minus memory minus carry, 11/15 clocks.
// RULE_19: Every form updates all six arithmetic flags.
// RULE_20: Size bit zero means byte, one means word.
// RULE_21: Flags follow conventional carry, overflow, parity meaning.
module asx_core
    import asx_pkg::*;
#(
    parameter int BUS16 = 1,  // One selects the 16-bit bus variant.
    parameter int AW    = 20  // Memory address width.
)(
    input  wire logic          CLOCK,     // System clock.
    input  wire logic          RSTN,      // Synchronous reset, active low.
    input  wire logic          WB_CYC_I,  // Bus cycle.
    input  wire logic          WB_STB_I,  // Bus strobe.
    input  wire logic          WB_WE_I,   // Write enable.
    input  wire logic [7:0]    WB_ADR_I,  // Byte address.
    input  wire logic [3:0]    WB_SEL_I,  // Byte lanes.
    input  wire logic [31:0]   WB_DAT_I,  // Write data.
    output logic      [31:0]   WB_DAT_O,  // Read data.
    output logic               WB_ACK_O,  // Acknowledge.
    output logic      [AW-1:0] MEM_ADDR,  // Memory operand address.
    output logic      [15:0]   MEM_WDATA, // Memory write data.
    input  wire logic [15:0]   MEM_RDATA, // Memory read data pins.
    output logic               MEM_RD,    // Read transfer pulse.
    output logic               MEM_WR,    // Write transfer pulse.
    output logic               MEM_WORD,  // Transfer is a word.
    output logic               BUSY,      // Operation in progress.
    output logic               DONE       // Operation finished pulse.
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (BUS16 != 0 && BUS16 != 1)
    begin : g_chk_bus
        $error("BUS16 must be 0 or 1.");
    end
    if (AW < 1 || AW > 31)
    begin : g_chk_aw
        $error("AW must lie between 1 and 31.");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    asx_state_t    state, next_state;
    asx_op_t       op, next_op;
    asx_form_t     form, next_form;
    logic          w, next_w;
    logic [2:0]    dst, next_dst;
    logic [2:0]    src, next_src;
    logic [4:0]    el, next_el;
    logic [15:0]   imm, next_imm;
    logic [AW-1:0] maddr, next_maddr;
    logic [15:0]   rf [8];
    logic [15:0]   next_rf [8];
    logic [5:0]    flags, next_flags;
    logic [15:0]   mval, next_mval;
    logic [15:0]   rd_s1, rd_s2;
    logic [31:0]   dat_o, next_dat_o;
    logic          ack, next_ack;
    logic [AW-1:0] m_addr, next_m_addr;
    logic [15:0]   m_wdata, next_m_wdata;
    logic          m_rd, next_m_rd;
    logic          m_wr, next_m_wr;
    logic          m_word, next_m_word;
    logic          done, next_done;

    // Datapath terms.
    logic [15:0]   mask, opa, opb, res;
    logic [16:0]   wide;
    logic [4:0]    half;
    logic          cin, sub_op, mem_src, mem_dst, last;
    logic          sa, sb, sr;
    logic [5:0]    new_flags;
    logic [4:0]    total;
    logic [2:0]    wdst;

    // ----------------------------------------------------------------
    // Clock count of a form
    // ----------------------------------------------------------------
    // Words on the narrow bus, or odd words, take the long count.
    function automatic logic [4:0] clocks_of(asx_form_t f, logic wd, logic odd);
        logic fast;
        fast = !wd || (BUS16 != 0 && !odd);
        case (f)
            ASX_RR:  clocks_of = `ASX_T_RR;
            ASX_RI:  clocks_of = `ASX_T_IMM;
            ASX_AI:  clocks_of = `ASX_T_IMM;
            ASX_RM:  clocks_of = fast ? `ASX_T_RM_S : `ASX_T_RM_L;
            ASX_MR:  clocks_of = fast ? `ASX_T_MR_S : `ASX_T_MR_L;
            ASX_MI:  clocks_of = fast ? `ASX_T_MI_S : `ASX_T_MI_L;
            default: clocks_of = `ASX_T_RR;
        endcase
    endfunction : clocks_of

    // Forms that read memory.
    function automatic logic reads_mem(asx_form_t f);
        reads_mem = (f == ASX_MR) || (f == ASX_RM) || (f == ASX_MI);
    endfunction : reads_mem

    // Byte-lane merge of a 16-bit register.
    function automatic logic [15:0] lanes(logic [15:0] old, logic [3:0] sel,
                                          logic [31:0] d);
        lanes = old;
        if (sel[0])
        begin
            lanes[7:0] = d[7:0];
        end
        if (sel[1])
        begin
            lanes[15:8] = d[15:8];
        end
    endfunction : lanes

    // ----------------------------------------------------------------
    // Arithmetic and flags
    // ----------------------------------------------------------------
    // Operand select, add or subtract with carry, and the six flags.
    always_comb
    begin
        mask    = w ? 16'hFFFF : 16'h00FF; // RULE_20
        sub_op  = (op == ASX_SUB) || (op == ASX_SUB_WB);
        cin     = ((op == ASX_ADD_PC) || (op == ASX_SUB_WB)) ? flags[`ASX_FL_CARRY] : 1'b0; // RULE_04
        mem_src = reads_mem(form);
        mem_dst = (form == ASX_MR) || (form == ASX_MI);
        wdst    = (form == ASX_AI) ? 3'h0 : dst; // RULE_03
        case (form)
            ASX_MR:  begin opa = mval;    opb = rf[src]; end // RULE_05 RULE_17
            ASX_RM:  begin opa = rf[dst]; opb = mval;    end // RULE_06
            ASX_RI:  begin opa = rf[dst]; opb = imm;     end // RULE_01
            ASX_MI:  begin opa = mval;    opb = imm;     end // RULE_02
            ASX_AI:  begin opa = rf[0];   opb = imm;     end // RULE_09
            default: begin opa = rf[dst]; opb = rf[src]; end // RULE_10
        endcase
        opa = opa & mask;
        opb = opb & mask;
        if (sub_op)
        begin
            wide = {1'b0, opa} - {1'b0, opb} - {16'h0000, cin}; // RULE_16
            half = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
        end
        else
        begin
            wide = {1'b0, opa} + {1'b0, opb} + {16'h0000, cin}; // RULE_07
            half = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        end
        res = wide[15:0] & mask;
        sa  = w ? opa[15] : opa[7];
        sb  = w ? opb[15] : opb[7];
        sr  = w ? res[15] : res[7];
        // Flags follow carry, borrow, signed overflow and low-byte parity.
        new_flags[`ASX_FL_CARRY] = w ? wide[16] : wide[8]; // RULE_21
        new_flags[`ASX_FL_HALF]  = half[4];
        new_flags[`ASX_FL_OVF]   = sub_op ? (sa != sb) && (sr != sa) : (sa == sb) && (sr != sa);
        new_flags[`ASX_FL_SIGN]  = sr;
        new_flags[`ASX_FL_ZERO]  = (res == 16'h0000);
        new_flags[`ASX_FL_PAR]   = ~^res[7:0];
        total = clocks_of(form, w, maddr[0]);
        last  = (state == ASX_RUN) && (el == total - 5'h01);
    end

    // ----------------------------------------------------------------
    // Bus slave and sequencer
    // ----------------------------------------------------------------
    // Register access, command start and the run sequence.
    always_comb
    begin
        logic       hit;
        logic       wr_take;
        asx_form_t  nf;
        hit          = WB_CYC_I && WB_STB_I;
        wr_take      = hit && ack && WB_WE_I;
        nf           = asx_form_t'(WB_DAT_I[`ASX_C_FORM_LO +: 3]);
        next_state   = state;
        next_op      = op;
        next_form    = form;
        next_w       = w;
        next_dst     = dst;
        next_src     = src;
        next_el      = el;
        next_imm     = imm;
        next_maddr   = maddr;
        next_rf      = rf;
        next_flags   = flags;
        next_mval    = mval;
        next_m_addr  = m_addr;
        next_m_wdata = m_wdata;
        next_m_rd    = 1'b0;
        next_m_wr    = 1'b0;
        next_m_word  = m_word;
        next_done    = 1'b0;
        next_ack     = hit && !ack;
        next_dat_o   = 32'h0000_0000;
        // Read data is prepared while the acknowledge is being raised.
        if (hit && !ack && !WB_WE_I)
        begin
            if (WB_ADR_I == `ASX_A_CMD)
            begin
                next_dat_o = {20'h00000, src, dst, w, form, op};
            end
            else if (WB_ADR_I == `ASX_A_IMM)
            begin
                next_dat_o = {16'h0000, imm};
            end
            else if (WB_ADR_I == `ASX_A_MADDR)
            begin
                next_dat_o = 32'(maddr);
            end
            else if (WB_ADR_I == `ASX_A_FLAGS)
            begin
                next_dat_o = {26'h0000000, flags};
            end
            else if (WB_ADR_I == `ASX_A_STATUS)
            begin
                next_dat_o = {31'h00000000, state == ASX_RUN};
            end
            else if (WB_ADR_I[7:5] == `ASX_A_RF_HI && WB_ADR_I[1:0] == 2'h0)
            begin
                next_dat_o = {16'h0000, rf[WB_ADR_I[4:2]]};
            end
        end
        // Writes land at the acknowledge edge; writes while busy are acknowledged and dropped.
        if (wr_take && state == ASX_IDLE)
        begin
            if (WB_ADR_I == `ASX_A_IMM)
            begin
                next_imm = lanes(imm, WB_SEL_I, WB_DAT_I);
            end
            else if (WB_ADR_I == `ASX_A_MADDR && WB_SEL_I == 4'hF)
            begin
                next_maddr = WB_DAT_I[AW-1:0];
            end
            else if (WB_ADR_I == `ASX_A_FLAGS && WB_SEL_I[0])
            begin
                next_flags = WB_DAT_I[5:0];
            end
            else if (WB_ADR_I[7:5] == `ASX_A_RF_HI && WB_ADR_I[1:0] == 2'h0)
            begin
                next_rf[WB_ADR_I[4:2]] = lanes(rf[WB_ADR_I[4:2]], WB_SEL_I, WB_DAT_I);
            end
            else if (WB_ADR_I == `ASX_A_CMD && WB_SEL_I == 4'hF && nf <= ASX_AI)
            begin
                next_op    = asx_op_t'(WB_DAT_I[`ASX_C_OP_LO +: 2]);
                next_form  = nf;
                next_w     = WB_DAT_I[`ASX_C_WORD]; // RULE_20
                next_dst   = WB_DAT_I[`ASX_C_DST_LO +: 3];
                next_src   = WB_DAT_I[`ASX_C_SRC_LO +: 3];
                if (WB_DAT_I[`ASX_C_START])
                begin
                    next_state  = ASX_RUN;
                    next_el     = 5'h00;
                    next_m_rd   = reads_mem(nf); // RULE_12
                    next_m_addr = maddr;
                    next_m_word = WB_DAT_I[`ASX_C_WORD];
                end
            end
        end
        case (state)
            ASX_IDLE:
            begin
                next_el = 5'h00;
            end
            ASX_RUN:
            begin
                next_el = el + 5'h01;
                // The read operand is taken from the synchronised pins.
                if (mem_src && el == `ASX_RD_CAP)
                begin
                    next_mval = rd_s2; // RULE_18
                end
                // Memory destinations get the second transfer in the last cycle.
                if (mem_dst && el == total - 5'h02)
                begin
                    next_m_wr    = 1'b1; // RULE_11
                    next_m_wdata = res; // RULE_14
                end
                if (last)
                begin
                    next_state = ASX_IDLE;
                    next_done  = 1'b1;
                    next_flags = new_flags; // RULE_19
                    if (!mem_dst)
                    begin
                        next_rf[wdst] = w ? res : {rf[wdst][15:8], res[7:0]}; // RULE_15
                    end
                end
            end
            default:
            begin
                next_state = ASX_IDLE;
            end
        endcase
    end

    // Registers of the bus slave, sequencer and datapath.
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            state   <= ASX_IDLE;
            op      <= ASX_ADD;
            form    <= ASX_RR;
            w       <= 1'b0;
            dst     <= 3'h0;
            src     <= 3'h0;
            el      <= 5'h00;
            imm     <= 16'h0000;
            maddr   <= '0;
            flags   <= `ASX_FL_RST;
            mval    <= 16'h0000;
            rd_s1   <= 16'h0000;
            rd_s2   <= 16'h0000;
            dat_o   <= 32'h0000_0000;
            ack     <= 1'b0;
            m_addr  <= '0;
            m_wdata <= 16'h0000;
            m_rd    <= 1'b0;
            m_wr    <= 1'b0;
            m_word  <= 1'b0;
            done    <= 1'b0;
            for (int i = 0; i < 8; i++)
            begin
                rf[i] <= 16'h0000;
            end
        end
        else
        begin
            state   <= next_state;
            op      <= next_op;
            form    <= next_form;
            w       <= next_w;
            dst     <= next_dst;
            src     <= next_src;
            el      <= next_el;
            imm     <= next_imm;
            maddr   <= next_maddr;
            flags   <= next_flags;
            mval    <= next_mval;
            rd_s1   <= MEM_RDATA;
            rd_s2   <= rd_s1;
            dat_o   <= next_dat_o;
            ack     <= next_ack;
            m_addr  <= next_m_addr;
            m_wdata <= next_m_wdata;
            m_rd    <= next_m_rd;
            m_wr    <= next_m_wr;
            m_word  <= next_m_word;
            done    <= next_done;
            rf      <= next_rf;
        end
    end

    // Outputs come straight from their flip-flops.
    assign WB_DAT_O  = dat_o;
    assign WB_ACK_O  = ack;
    assign MEM_ADDR  = m_addr;
    assign MEM_WDATA = m_wdata;
    assign MEM_RD    = m_rd;
    assign MEM_WR    = m_wr;
    assign MEM_WORD  = m_word;
    assign BUSY      = (state == ASX_RUN);
    assign DONE      = done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [4:0] run_len;
    logic [1:0] xfer;

    // Counts busy cycles and bus transfers of the current operation.
    always_ff @(posedge CLOCK)
    begin
        if (!RSTN)
        begin
            run_len <= 5'h00;
            xfer    <= 2'h0;
        end
        else
        begin
            run_len <= BUSY ? run_len + 5'h01 : 5'h00;
            xfer    <= BUSY ? xfer + {1'b0, m_rd} + {1'b0, m_wr} : 2'h0;
        end
    end

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    a_reg_reg_time: assert property ( // RULE_04
        $fell(BUSY) && form == ASX_RR |-> run_len == 5'd2)
        else $error("Register form took the wrong number of clocks.");

    a_imm_time: assert property ( // RULE_01
        $fell(BUSY) && (form == ASX_RI || form == ASX_AI) |-> run_len == 5'd4)
        else $error("Immediate form took the wrong number of clocks.");

    a_reg_mem_time: assert property ( // RULE_06
        $fell(BUSY) && form == ASX_RM
        |-> run_len == ((!w || (BUS16 != 0 && !maddr[0])) ? 5'd11 : 5'd15))
        else $error("Register-memory form took the wrong number of clocks.");

    a_mem_reg_time: assert property ( // RULE_05
        $fell(BUSY) && form == ASX_MR
        |-> run_len == ((!w || (BUS16 != 0 && !maddr[0])) ? 5'd16 : 5'd24))
        else $error("Memory-register form took the wrong number of clocks.");

    a_mem_imm_time: assert property ( // RULE_02
        $fell(BUSY) && form == ASX_MI
        |-> run_len == ((!w || (BUS16 != 0 && !maddr[0])) ? 5'd18 : 5'd26))
        else $error("Memory-immediate form took the wrong number of clocks.");

    a_no_bus_use: assert property ( // RULE_13
        BUSY && !mem_src |-> !MEM_RD && !MEM_WR)
        else $error("A register form made a bus transfer.");

    a_xfer_count: assert property ( // RULE_08
        $fell(BUSY) |-> xfer == (mem_dst ? 2'd2 : (mem_src ? 2'd1 : 2'd0)))
        else $error("Wrong number of bus transfers.");

    a_flag_update: assert property ( // RULE_19
        last |=> flags == $past(new_flags) && DONE)
        else $error("Flags not updated at the end of an operation.");

    a_borrow_out: assert property ( // RULE_21
        last && op == ASX_SUB |=> flags[`ASX_FL_CARRY] == ($past(opa) < $past(opb)))
        else $error("Borrow flag disagrees with the operands.");

    a_acc_write: assert property ( // RULE_03
        last && form == ASX_AI && w |=> rf[0] == $past(res))
        else $error("Accumulator word not written with the result.");

endmodule : asx_core

// [dv/asx_mem_model.sv]
// Memory partner that answers operand reads and keeps write-backs.
module asx_mem_model
(
    input  wire logic        clk,   // Clock.
    input  wire logic [19:0] addr,  // Operand address.
    input  wire logic [15:0] wdata, // Write data.
    input  wire logic        rd,    // Read pulse.
    input  wire logic        wr,    // Write pulse.
    input  wire logic        word,  // Word transfer.
    output logic      [15:0] rdata  // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    int         age = 99;
    initial rdata = 16'hA5C3;
    // Data shows two cycles after a read and holds past capture.
    // Once age passes nine the bus toggles; until the data shows it holds its old value.
    always @(posedge clk)
    begin
        age <= rd ? 0 : age + 1;
        if (age == 1)
            rdata <= {mem[addr[7:0] + 8'h01], mem[addr[7:0]]};
        else if (age > 9)
            rdata <= ~rdata;
        if (wr)
            mem[addr[7:0]] <= wdata[7:0];
        if (wr && word)
            mem[addr[7:0] + 8'h01] <= wdata[15:8];
    end
endmodule : asx_mem_model

// [dv/tb_top.sv]
// Self-checking bench for the add/subtract unit.
`include "asx_cfg.svh"
module tb_top
    import asx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat;
    logic        ack, rd, wr, word, busy, done;
    logic [19:0] maddr;
    logic [15:0] wd, rdd;
    logic [15:0] rf [8];
    logic [31:0] q [$];
    int          miscompares = 0, total_checks = 0, bc = 0, rc = 0, wc = 0;
    int          seed = 32'hf72e;

    asx_core DUT (.CLOCK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .MEM_ADDR(maddr), .MEM_WDATA(wd),
        .MEM_RDATA(rdd), .MEM_RD(rd), .MEM_WR(wr), .MEM_WORD(word), .BUSY(busy), .DONE(done));
    asx_mem_model u_mem (.clk(clk), .addr(maddr), .wdata(wd), .rd(rd), .wr(wr), .word(word), .rdata(rdd));

    // Free-running 100 MHz clock.
    initial
    begin
        forever #5 clk = ~clk;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task give_verdict;
        $display("Checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // One classic cycle: hold everything until ack is sampled, then release.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            give_verdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rdchk

    // Reference result and flags: {ovf, sign, zero, half, parity, carry, result}.
    function automatic logic [21:0] alu(input logic [1:0] op, input logic w, input logic [15:0] a,
                                        input logic [15:0] b, input logic c);
        logic [17:0] s;
        logic [4:0]  h;
        logic [15:0] r;
        logic        ci, sa, sb, sr;
        ci = op[0] & c;
        if (!w)
        begin
            a[15:8] = 8'h00;
            b[15:8] = 8'h00;
        end
        s = op[1] ? a - b - ci : a + b + ci;
        h = op[1] ? a[3:0] - b[3:0] - ci : a[3:0] + b[3:0] + ci;
        r = w ? s[15:0] : {8'h00, s[7:0]};
        sa = w ? a[15] : a[7];
        sb = w ? b[15] : b[7];
        sr = w ? r[15] : r[7];
        return {sa != sr && (op[1] ? sa != sb : sa == sb), sr, r == 16'h0, h[4], ~^r[7:0], w ? s[16] : s[8], r};
    endfunction : alu

    // Loads operands, starts one command and checks its outcome.
    task run_op(input logic [1:0] op, input logic [2:0] f, input logic w, input logic al);
        logic [2:0]  d, s;
        logic [15:0] m, b, r;
        logic [7:0]  ma, fl, n, ra;
        logic [21:0] x;
        logic [31:0] t;
        logic        lg;
        int          k;
        d = (f == ASX_AI) ? 3'h0 : 3'($random(seed));
        s = 3'($random(seed));
        rf[d] = 16'($random(seed));
        rf[s] = 16'($random(seed));
        m = 16'($random(seed));
        b = 16'($random(seed));
        fl = 8'($random(seed));
        ma = {7'($random(seed)), al};
        ra = {`ASX_A_RF_HI, d, 2'b00};
        lg = w & al;
        u_mem.mem[ma] = m[7:0];
        u_mem.mem[ma + 8'h01] = m[15:8];
        wb(1'b1, ra, {16'h0, rf[d]});
        wb(1'b1, {`ASX_A_RF_HI, s, 2'b00}, {16'h0, rf[s]});
        wb(1'b1, `ASX_A_IMM, {16'h0, b});
        wb(1'b1, `ASX_A_FLAGS, {26'h0, fl[5:0]});
        wb(1'b1, `ASX_A_MADDR, {24'h0, ma});
        if (f == ASX_RM)
            b = m;
        else if (f inside {ASX_RR, ASX_MR})
            b = rf[s];
        x = alu(op, w, (f inside {ASX_MR, ASX_MI}) ? m : rf[d], b, fl[0]);
        case (f)
            ASX_RR: n = 8'h02;
            ASX_RM: n = lg ? 8'h0F : 8'h0B;
            ASX_MR: n = lg ? 8'h18 : 8'h10;
            ASX_MI: n = lg ? 8'h1A : 8'h12;
            default: n = 8'h04;
        endcase
        t = {15'h0, f inside {ASX_MR, ASX_RM, ASX_MI}, 7'h0, f inside {ASX_MR, ASX_MI}, n};
        q.push_back(t);
        wb(1'b1, `ASX_A_CMD, {1'b1, 19'h0, s, d, w, f, op});
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end while (done !== 1'b1 && k < 40);
        if (k >= 40)
        begin
            miscompares++;
            give_verdict();
        end
        rdchk(`ASX_A_FLAGS, {26'h0, x[21:16]});
        if (f inside {ASX_MR, ASX_MI})
        begin
            r = {w ? x[15:8] : m[15:8], x[7:0]};
            m = {u_mem.mem[ma + 8'h01], u_mem.mem[ma]};
            chk("memory", {16'h0, r}, {16'h0, m});
        end
        else
        begin
            rf[d] = w ? x[15:0] : {rf[d][15:8], x[7:0]};
            rdchk(ra, {16'h0, rf[d]});
        end
        $display("Done op %0d form %0d word %0d", op, f, w);
    endtask : run_op

    // Compares read answers and finished operations with the oldest note.
    always @(posedge clk)
    begin
        if (busy === 1'b1)
            bc++;
        if (rd === 1'b1)
            rc++;
        if (wr === 1'b1)
            wc++;
        if (ack === 1'b1 && we === 1'b0)
            chk("read data", q.pop_front(), rdat);
        if (done === 1'b1)
        begin
            chk("clocks and transfers", q.pop_front(), {8'h00, rc[7:0], wc[7:0], bc[7:0]});
            bc = 0;
            rc = 0;
            wc = 0;
        end
    end

    // Reset, then every operation, form, size and alignment.
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdchk(`ASX_A_FLAGS, 32'h0);
        for (int o = 0; o < 4; o++)
            for (int f = 0; f < 6; f++)
                for (int i = 0; i < 4; i++)
                    run_op(o[1:0], f[2:0], i[0], i[1]);
        rdchk(8'hFC, 32'h0);
        give_verdict();
    end
endmodule : tb_top
